// >>> hdl/mrsf_crc.sv
// byte-serial crc-16 accumulator for rtu frames
// assumes start and valid are one-cycle strobes in the CLOCK domain
`timescale 1ns/1ps

module mrsf_crc (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic valid,
  input wire logic [7:0] data,
  output logic [15:0] crc
);
  import mrsf_pkg::*;

  // start seeds with all ones and folds the first byte in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc <= CRC_INIT;
    end else if (start) begin
      crc <= mrsf_crc_byte(CRC_INIT, data);
    end else if (valid) begin
      crc <= mrsf_crc_byte(crc, data);
    end
  end

endmodule

// >>> hdl/mrsf_fifo.sv
// flip-flop fifo with valid/ready on both sides
// assumes one clock; out_data is valid whenever out_valid is high
`timescale 1ns/1ps

module mrsf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // full and empty come from the true occupancy, so any depth works
  assign in_ready = (count != FULL);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers wrap at the last slot rather than relying on a power of two
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

// >>> hdl/mrsf_framer.sv
// rtu slave framer: byte stream in, frame delimiting, command handling, reply out
// assumes an external uart delivers received bytes as RX_VALID strobes and takes
// transmit bytes on TX_VALID/TX_READY; TX_EN drives the rs485 transceiver enable
//
// Functional notes
// - half duplex: receive is ignored while a reply is being driven out
// - own slave address comes from SLAVE_ADDR, legal values 1 to 127
// - address 0 is broadcast and accepted besides our own address
// - every valid individually addressed request gets a reply frame
// - broadcast requests are executed but never answered
// - each character carries one eight-bit frame byte
// - a new frame starts after 1.5 character times of idle bus or once the previous frame has closed
// - frame is complete after 3.5 idle character times following last byte
// - field order: address, function code, data words, crc
// - first byte of each frame is compared against our own address
// - gap over 1.5 character times discards the partial frame
// - gaps under 1.5 character times keep appending to the current frame
// - function 0x03 reads and 0x06 writes a parameter register
// - data field is 16-bit words, high byte first
// - every frame ends with crc over all preceding bytes
// - successful write is answered by an echo of the request
// - successful read answers address, 0x03, byte count word 2, value, crc
// - register 0x0003 is the frequency setpoint in tenths of a hertz
// - crc starts all ones, xor byte, eight right shifts with 0xA001
// - crc is sent low byte first, then high byte
// - errors answer function code plus 0x80 and an error word 1, 2 or 3
`timescale 1ns/1ps

module mrsf_framer #(
  parameter int HALF_CHAR_CYCLES = mrsf_pkg::HALF_CHAR_CYCLES,
  parameter int FIFO_DEPTH = mrsf_pkg::FIFO_DEPTH,
  parameter logic [15:0] SETPOINT_MAX = mrsf_pkg::SETPOINT_MAX
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_VALID,
  input wire logic [6:0] SLAVE_ADDR,
  input wire logic RUNNING,
  output logic [7:0] TX_DATA,
  output logic TX_VALID,
  input wire logic TX_READY,
  output logic TX_EN,
  output logic [15:0] FREQ_SETPOINT,
  output logic CRC_ERROR,
  output logic FRAME_DONE
);
  import mrsf_pkg::*;

  localparam logic [15:0] HALF_LAST = 16'(HALF_CHAR_CYCLES - 1);

  mrsf_state_t state;
  mrsf_state_t next_state;

  // gap timing
  logic [15:0] div_cnt;
  logic [2:0] gap_halves;
  logic in_frame;

  // receive buffer
  logic [7:0] rx_buf [8];
  logic [3:0] rx_cnt;
  logic [15:0] rx_crc;

  // reply buffer
  logic [7:0] rep [6];
  logic [2:0] rep_len;
  logic [2:0] rep_idx;
  logic [15:0] tx_crc;

  // transmit fifo
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [7:0] fifo_in_data;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;

  // byte taken only while listening and never in the closing cycle of a frame
  wire rx_take = RX_VALID && (state == ST_RECV) && !frame_end;
  wire half_tick = (div_cnt == HALF_LAST);
  wire gap_long = (gap_halves >= HALVES_ABORT);
  // a late byte opens a new frame, an early one extends the current
  wire start_new = rx_take && (!in_frame || gap_long);
  wire frame_end = in_frame && half_tick && (gap_halves == HALVES_END - 3'h1);
  wire [3:0] wr_idx = start_new ? 4'h0 : rx_cnt;
  wire out_take = fifo_out_valid && (!TX_VALID || TX_READY);
  wire out_pending = fifo_out_valid || TX_VALID;
  wire timer_clr = rx_take || ((state != ST_RECV) && (state != ST_DRAIN))
    || ((state == ST_DRAIN) && out_pending);

  // address filter on the first byte of the frame
  wire own_valid = (SLAVE_ADDR != 7'h00);
  wire addr_own = own_valid && (rx_buf[0] == {1'b0, SLAVE_ADDR});
  wire addr_bcast = (rx_buf[0] == ADDR_BCAST);
  wire crc_ok = (rx_crc == CRC_GOOD);
  wire len_ok = (rx_cnt == REQ_LEN);
  wire frame_ok = len_ok && crc_ok && (addr_own || addr_bcast);

  // request fields, words high byte first
  wire [7:0] req_fc = rx_buf[1];
  wire [15:0] req_reg = {rx_buf[2], rx_buf[3]};
  wire [15:0] req_word = {rx_buf[4], rx_buf[5]};
  wire reg_bad = (req_reg != REG_SETPOINT);
  wire is_read = (req_fc == FC_READ);
  wire is_write = (req_fc == FC_WRITE);

  // error priority: address first, then count or range, then run lock
  wire [7:0] read_err = reg_bad ? ERR_ADDR
    : (req_word != READ_COUNT) ? ERR_VALUE : ERR_NONE;
  wire [7:0] write_err = reg_bad ? ERR_ADDR
    : (req_word > SETPOINT_MAX) ? ERR_VALUE
    : RUNNING ? ERR_RUNNING : ERR_NONE;
  // unknown function codes are answered as a bad address
  wire [7:0] exec_err = is_read ? read_err : is_write ? write_err : ERR_ADDR;
  wire exec_ok = (exec_err == ERR_NONE);
  wire do_write = is_write && exec_ok;

  // state sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_RECV: begin
        if (frame_end && frame_ok) begin
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        // broadcasts are executed silently to avoid slave collisions
        next_state = addr_bcast ? ST_RECV : ST_SEND;
      end
      ST_SEND: begin
        if (fifo_in_ready && (rep_idx == rep_len - 3'h1)) begin
          next_state = ST_CRC_LO;
        end
      end
      ST_CRC_LO: begin
        if (fifo_in_ready) begin
          next_state = ST_CRC_HI;
        end
      end
      ST_CRC_HI: begin
        if (fifo_in_ready) begin
          next_state = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        // hold the line one more character so the last stop bit leaves
        if (!out_pending && (gap_halves == HALVES_HOLD)) begin
          next_state = ST_RECV;
        end
      end
      default: begin
        next_state = ST_RECV;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_RECV;
    end else begin
      state <= next_state;
    end
  end

  // half-character divider, realigned to every received byte
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      div_cnt <= 16'h0000;
    end else if (timer_clr || half_tick) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  // idle time since the last byte, in half characters, saturating
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      gap_halves <= HALVES_END;
    end else if (timer_clr) begin
      gap_halves <= 3'h0;
    end else if (half_tick && (gap_halves != HALVES_END)) begin
      gap_halves <= gap_halves + 3'h1;
    end
  end

  // frame open from its first byte until 3.5 idle characters
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      in_frame <= 1'b0;
    end else if (rx_take) begin
      in_frame <= 1'b1;
    end else if (frame_end || (state != ST_RECV)) begin
      in_frame <= 1'b0;
    end
  end

  // byte count saturates so an overlong frame can never match the length
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rx_cnt <= 4'h0;
    end else if (start_new) begin
      rx_cnt <= 4'h1;
    end else if (rx_take && (rx_cnt != LEN_FULL)) begin
      rx_cnt <= rx_cnt + 4'h1;
    end
  end

  // only the first eight bytes are kept, eight bits each
  always_ff @(posedge CLOCK) begin
    if (rx_take && !wr_idx[3]) begin
      rx_buf[wr_idx[2:0]] <= RX_DATA;
    end
  end

  // receive crc runs over the trailing crc too; a good frame leaves zero
  mrsf_crc u_rx_crc (
    .clk(CLOCK),
    .rst_n(RST_N),
    .start(start_new),
    .valid(rx_take),
    .data(RX_DATA),
    .crc(rx_crc)
  );

  // reply build in the execute cycle
  always_ff @(posedge CLOCK) begin
    if (state == ST_EXEC) begin
      rep[0] <= rx_buf[0];
      if (!exec_ok) begin
        rep[1] <= req_fc | FC_ERR_FLAG;
        rep[2] <= 8'h00;
        rep[3] <= exec_err;
        rep[4] <= 8'h00;
        rep[5] <= 8'h00;
        rep_len <= REPLY_LEN_ERR;
      end else if (is_read) begin
        rep[1] <= FC_READ;
        rep[2] <= READ_BYTES[15:8];
        rep[3] <= READ_BYTES[7:0];
        rep[4] <= FREQ_SETPOINT[15:8];
        rep[5] <= FREQ_SETPOINT[7:0];
        rep_len <= REPLY_LEN_OK;
      end else begin
        // echo; recomputed crc equals the request crc
        rep[1] <= rx_buf[1];
        rep[2] <= rx_buf[2];
        rep[3] <= rx_buf[3];
        rep[4] <= rx_buf[4];
        rep[5] <= rx_buf[5];
        rep_len <= REPLY_LEN_OK;
      end
    end
  end

  // setpoint register, written by a good write even when broadcast
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      FREQ_SETPOINT <= SETPOINT_RESET;
    end else if ((state == ST_EXEC) && do_write) begin
      FREQ_SETPOINT <= req_word;
    end
  end

  // reply byte index
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rep_idx <= 3'h0;
    end else if (state == ST_EXEC) begin
      rep_idx <= 3'h0;
    end else if ((state == ST_SEND) && fifo_in_ready) begin
      rep_idx <= rep_idx + 3'h1;
    end
  end

  // fifo feed: reply bytes, then crc low and high
  assign fifo_in_valid = (state == ST_SEND) || (state == ST_CRC_LO) || (state == ST_CRC_HI);
  assign fifo_in_data = (state == ST_CRC_LO) ? tx_crc[7:0]
    : (state == ST_CRC_HI) ? tx_crc[15:8] : rep[rep_idx];

  mrsf_crc u_tx_crc (
    .clk(CLOCK),
    .rst_n(RST_N),
    .start((state == ST_SEND) && fifo_in_ready && (rep_idx == 3'h0)),
    .valid((state == ST_SEND) && fifo_in_ready),
    .data(fifo_in_data),
    .crc(tx_crc)
  );

  // a full fifo stalls the reply sequence above
  mrsf_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(CLOCK),
    .rst_n(RST_N),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(out_take),
    .out_data(fifo_out_data)
  );

  // output byte register toward the uart
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      TX_VALID <= 1'b0;
      TX_DATA <= 8'h00;
    end else if (out_take) begin
      TX_VALID <= 1'b1;
      TX_DATA <= fifo_out_data;
    end else if (TX_READY) begin
      TX_VALID <= 1'b0;
    end
  end

  // driver enable; replies only start after the request's 3.5 char idle
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      TX_EN <= 1'b0;
    end else begin
      TX_EN <= (state == ST_SEND) || (state == ST_CRC_LO)
        || (state == ST_CRC_HI) || (state == ST_DRAIN);
    end
  end

  // status pulses at frame end: crc failure and accepted frame
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      CRC_ERROR <= 1'b0;
      FRAME_DONE <= 1'b0;
    end else begin
      CRC_ERROR <= frame_end && !crc_ok;
      FRAME_DONE <= frame_end && frame_ok;
    end
  end

endmodule

// >>> inc/mrsf_pkg.sv
// shared constants, state codes and the crc step for the rtu slave framer
// assumes a single 25 MHz clock and byte-wide serial characters

package mrsf_pkg;

  // clock and character timing
  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD = 9600;
  localparam int BITS_PER_CHAR = 11; // start, 8 data, parity, stop
  // half a character time in cycles, rounded down
  localparam int HALF_CHAR_CYCLES = (CLK_HZ * BITS_PER_CHAR) / (2 * BAUD);
  localparam logic [2:0] HALVES_ABORT = 3'h3; // 1.5 character times
  localparam logic [2:0] HALVES_END = 3'h7; // 3.5 character times
  localparam logic [2:0] HALVES_HOLD = 3'h2; // 1 character time

  // frame layout
  localparam logic [3:0] REQ_LEN = 4'h8;
  localparam logic [3:0] LEN_FULL = 4'hF;
  localparam logic [2:0] REPLY_LEN_OK = 3'h6;
  localparam logic [2:0] REPLY_LEN_ERR = 3'h4;
  localparam logic [7:0] ADDR_BCAST = 8'h00;

  // function codes and register map
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WRITE = 8'h06;
  localparam logic [7:0] FC_ERR_FLAG = 8'h80;
  localparam logic [15:0] REG_SETPOINT = 16'h0003;
  localparam logic [15:0] READ_COUNT = 16'h0001;
  localparam logic [15:0] READ_BYTES = 16'h0002;
  localparam logic [15:0] SETPOINT_RESET = 16'h0000;
  localparam logic [15:0] SETPOINT_MAX = 16'h0FA0; // 400.0 Hz in tenths

  // exception codes
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_ADDR = 8'h01;
  localparam logic [7:0] ERR_VALUE = 8'h02;
  localparam logic [7:0] ERR_RUNNING = 8'h03;

  // crc
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] CRC_GOOD = 16'h0000;

  // transmit buffer
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 32;

  typedef enum logic [2:0] {
    ST_RECV = 3'h0,
    ST_EXEC = 3'h1,
    ST_SEND = 3'h2,
    ST_CRC_LO = 3'h3,
    ST_CRC_HI = 3'h4,
    ST_DRAIN = 3'h5
  } mrsf_state_t;

  // one byte folded into the crc, lsb first, reflected polynomial
  function automatic logic [15:0] mrsf_crc_byte(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage

// >>> testbench/mrsf_framer_asserts.sv
// port-level assertions for the rtu slave framer
// assumes the bind below attaches it to every mrsf_framer instance
`timescale 1ns/1ps

module mrsf_framer_asserts #(
  parameter int HALF_CHAR_CYCLES = 14322
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_VALID,
  input wire logic [6:0] SLAVE_ADDR,
  input wire logic RUNNING,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  input wire logic TX_READY,
  input wire logic TX_EN,
  input wire logic [15:0] FREQ_SETPOINT,
  input wire logic CRC_ERROR,
  input wire logic FRAME_DONE
);
  logic [19:0] quiet;

  // cycles since the last received byte; saturates so a long idle never wraps
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      quiet <= 20'h00000;
    end else if (RX_VALID) begin
      quiet <= 20'h00000;
    end else if (quiet != 20'hFFFFF) begin
      quiet <= quiet + 20'h00001;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  a_tx_byte_held: assert property (
    TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("reply byte changed before it was taken");
  a_valid_inside_en: assert property (TX_VALID |-> TX_EN)
    else $error("reply byte offered while the driver is off");
  a_en_after_done: assert property ($rose(TX_EN) |-> $past(FRAME_DONE, 2))
    else $error("driver enabled without an accepted frame");
  a_first_byte_soon: assert property ($rose(TX_EN) |=> TX_VALID)
    else $error("first reply byte late");
  a_end_after_idle: assert property (
    FRAME_DONE || CRC_ERROR |-> quiet >= 7 * HALF_CHAR_CYCLES - 1)
    else $error("frame closed before 3.5 idle characters");
  a_setpoint_cause: assert property (
    $changed(FREQ_SETPOINT) |-> FRAME_DONE || $past(FRAME_DONE) || $past(FRAME_DONE, 2))
    else $error("setpoint changed without a frame");
  a_flags_pulse: assert property (
    FRAME_DONE || CRC_ERROR |=> !FRAME_DONE && !CRC_ERROR)
    else $error("frame flag longer than one cycle");
  a_en_release: assert property ($fell(TX_EN) |-> !$past(TX_VALID) && !TX_VALID)
    else $error("driver released with a byte pending");
endmodule

bind mrsf_framer mrsf_framer_asserts #(.HALF_CHAR_CYCLES(HALF_CHAR_CYCLES)) u_mrsf_framer_asserts (
  .CLOCK(CLOCK), .RST_N(RST_N), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID),
  .SLAVE_ADDR(SLAVE_ADDR), .RUNNING(RUNNING), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
  .TX_READY(TX_READY), .TX_EN(TX_EN), .FREQ_SETPOINT(FREQ_SETPOINT),
  .CRC_ERROR(CRC_ERROR), .FRAME_DONE(FRAME_DONE));

// >>> testbench/mrsf_host.sv
// bus master model: sends request bytes, takes reply bytes
// assumes the testbench calls send_byte; slow makes it stall replies
`timescale 1ns/1ps

module mrsf_host (
  input wire logic clk,
  input wire logic slow,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic got_valid,
  output logic [7:0] got_data
);
  initial begin
    tx_ready = 1'b1;
    rx_data = 8'h5A;
    rx_valid = 1'b0;
    got_valid = 1'b0;
    got_data = 8'h00;
  end

  // take reply bytes; a slow host stalls about two cycles in three
  always @(posedge clk) begin
    got_valid <= tx_valid && tx_ready;
    got_data <= tx_data;
    tx_ready <= slow ? ($urandom % 3 == 0) : 1'b1;
  end

  // one eight-bit character per strobe, then the line shows junk
  task automatic send_byte(input logic [7:0] b, input int gap);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
    repeat (gap) @(posedge clk);
  endtask
endmodule

// >>> testbench/test_mrsf_framer.sv
// self-checking bench for the rtu slave framer with a host model
// assumes a short half-character count so frames finish quickly
`timescale 1ns/1ps

module test_mrsf_framer;
  import mrsf_pkg::*;
  localparam int HALF = 20;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic running = 1'b0;
  logic slow = 1'b0;
  logic [7:0] rx_data, tx_data, got_data, e;
  logic rx_valid, tx_valid, tx_ready, tx_en, crc_err, done, got_valid;
  logic [15:0] setpoint, sp, r, w;
  logic [7:0] a, fc, code;
  logic [3:0] mode;
  logic [7:0] m [6];
  logic [7:0] exp_q [$];
  int n_errors = 0;
  int n_compared = 0;
  int n_crc = 0;
  int crc_exp = 0;
  int n_done = 0;
  int done_exp = 0;
  // mode nibble: bit0 running, 2 bad crc, 4 stray prefix, 6 random value
  logic [51:0] tc [13] = '{52'h0_01_06_0003_01F4, 52'h0_01_03_0003_0001,
    52'h0_01_03_0003_0002, 52'h0_01_03_0005_0001, 52'h0_01_06_0003_0FA1,
    52'h1_01_06_0003_0258, 52'h0_01_10_0003_0001, 52'h6_00_06_0003_0000,
    52'h0_01_03_0003_0001, 52'h0_22_06_0003_0100, 52'h2_01_06_0003_0100,
    52'h4_01_06_0003_0FA0, 52'h6_01_06_0003_0000};

  always #20 CLOCK = ~CLOCK;

  mrsf_framer #(.HALF_CHAR_CYCLES(HALF), .FIFO_DEPTH(32), .SETPOINT_MAX(16'h0FA0)) u_mrsf_framer (
    .CLOCK(CLOCK), .RST_N(RST_N), .RX_DATA(rx_data), .RX_VALID(rx_valid),
    .SLAVE_ADDR(7'h01), .RUNNING(running), .TX_DATA(tx_data), .TX_VALID(tx_valid),
    .TX_READY(tx_ready), .TX_EN(tx_en), .FREQ_SETPOINT(setpoint), .CRC_ERROR(crc_err),
    .FRAME_DONE(done));

  mrsf_host u_mrsf_host (.clk(CLOCK), .slow(slow), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .got_valid(got_valid),
    .got_data(got_data));

  function automatic logic [15:0] crc_add(input logic [15:0] cin, input logic [7:0] d);
    logic [15:0] t;
    t = cin ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      t = t[0] ? ((t >> 1) ^ 16'hA001) : (t >> 1);
    end
    return t;
  endfunction

  task automatic chk(input string name, input logic [15:0] ev, input logic [15:0] g);
    n_compared++;
    if (g !== ev) begin
      $display("CHECK FAILED %s expected %h seen %h", name, ev, g);
      n_errors++;
    end
  endtask

  task automatic report_and_stop();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // frame bytes then crc, low byte first; either sent or noted as expected
  task automatic msg(input int n, input bit send, input bit bad, input int g3);
    logic [15:0] k;
    k = 16'hFFFF;
    for (int i = 0; i < n; i++) begin
      k = crc_add(k, m[i]);
      if (send) u_mrsf_host.send_byte(m[i], (i == 3) ? g3 : $urandom_range(0, 6));
      else exp_q.push_back(m[i]);
    end
    if (bad) k = k ^ 16'h0100;
    if (send) u_mrsf_host.send_byte(k[7:0], 1);
    if (send) u_mrsf_host.send_byte(k[15:8], 0);
    if (!send) exp_q.push_back(k[7:0]);
    if (!send) exp_q.push_back(k[15:8]);
  endtask

  // compare each reply byte with the oldest note
  always @(posedge CLOCK) begin
    if (crc_err === 1'b1) n_crc++;
    if (done === 1'b1) n_done++;
    if (got_valid === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
      chk("reply byte", {8'h00, e}, {8'h00, got_data});
    end
  end

  initial begin
    repeat (60000) @(posedge CLOCK);
    n_errors++;
    report_and_stop();
  end

  initial begin
    void'($urandom(1185));
    sp = 16'h0000;
    repeat (8) @(posedge CLOCK);
    chk("reset outputs", 16'h0000, {tx_valid, tx_en, crc_err, done, 12'h000});
    chk("reset setpoint", 16'h0000, setpoint);
    RST_N <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      {mode, a, fc, r, w} = tc[i];
      // only mode 6 randomises, so the prefix case keeps its exact upper bound
      if (mode[3:1] == 3'h3) w = 16'($urandom_range(0, 4000));
      @(posedge CLOCK);
      slow <= i[0];
      running <= mode[0];
      if (mode[3:1] == 3'h2) begin
        u_mrsf_host.send_byte(8'h01, 0);
        u_mrsf_host.send_byte(8'h06, 0);
        u_mrsf_host.send_byte(8'h00, 3 * HALF + 20);
      end
      m = '{a, fc, r[15:8], r[7:0], w[15:8], w[7:0]};
      code = 8'h00;
      if (!((fc == 8'h03 || fc == 8'h06) && r == 16'h0003)) code = 8'h01;
      else if (fc == 8'h03 ? w != 16'h0001 : w > 16'h0FA0) code = 8'h02;
      else if (fc == 8'h06 && mode[0]) code = 8'h03;
      msg(6, 1'b1, mode[3:1] == 3'h1, i[0] ? 2 * HALF + 10 : 1);
      if (mode[3:1] == 3'h1) crc_exp++;
      else if (a == 8'h00 || a == 8'h01) begin
        done_exp++;
        if (code == 8'h00 && fc == 8'h06) sp = w;
        if (a != 8'h00 && code != 8'h00) m = '{a, fc | 8'h80, 8'h00, code, 8'h00, 8'h00};
        if (a != 8'h00 && code == 8'h00 && fc == 8'h03) begin
          m = '{a, fc, 8'h00, 8'h02, sp[15:8], sp[7:0]};
        end
        if (a != 8'h00) msg(code != 8'h00 ? 4 : 6, 1'b0, 1'b0, 0);
      end
      repeat (7 * HALF + 4) @(posedge CLOCK);
      for (int k = 0; k < 2000 && (exp_q.size() != 0 || tx_en !== 1'b0); k++) @(posedge CLOCK);
      repeat (8 * HALF) @(posedge CLOCK);
      chk("bytes left", 16'h0000, 16'(exp_q.size()));
      chk("setpoint", sp, setpoint);
      chk("crc errors", 16'(crc_exp), 16'(n_crc));
      chk("frames accepted", 16'(done_exp), 16'(n_done));
      $display("test %0d done", i);
    end
    report_and_stop();
  end
endmodule
